// *** dds_fsk_frequency_synth.sv ***
// Functional notes
// - 24-bit phase accumulator on reference clock
// - Reference oscillator clock drives all logic
// - Accumulator adds step, wraps, addresses sine
// - 22-bit settings padded with two zero MSBs
// - Mode pin picks mode0 or mode1 setting
// - Modulation select bit 16 zero enables FSK
// - Deviation weighted by four in step
// - Transmit data high adds four times deviation
// - Settings kept through standby
// - Serial rising edge shifts, strobe loads latch
// - 24-bit words MSB first, last 24 kept
`include "dds_fsk_map.svh"
`timescale 1ns/1ps
`default_nettype none

module dds_fsk_frequency_synth (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic serial_strobe,
  input wire logic mode_select,
  input wire logic tx_data,
  input wire logic standby_n,
  output logic [`DAC_W-1:0] dac_code,
  output logic [`ACC_W-1:0] phase,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : strobe_merge

  function automatic logic mapped(input logic [7:0] a);
    return (a == `OFS_MODE0_FREQ) || (a == `OFS_MODE1_FREQ) || (a == `OFS_CONTROL) ||
           (a == `OFS_PHASE) || (a == `OFS_SAMPLE) || (a == `OFS_SHIFT);
  endfunction : mapped

  function automatic logic [9:0] quarter_amp(input logic [3:0] i);
    logic [9:0] t [16];
    t = '{10'h032, 10'h096, 10'h0f9, 10'h159, 10'h1b6, 10'h20e, 10'h262, 10'h2b0,
          10'h2f7, 10'h337, 10'h370, 10'h3a0, 10'h3c7, 10'h3e5, 10'h3f9, 10'h3fe};
    return t[i];
  endfunction : quarter_amp

  // ==========================================================
  // Pin synchronisers
  dds_fsk_pkg::pin_set_t pins_in;
  dds_fsk_pkg::pin_set_t meta_q, meta_d;
  dds_fsk_pkg::pin_set_t sync_q, sync_d;
  logic sclk_prev_q, sclk_prev_d;
  logic strobe_prev_q, strobe_prev_d;

  always_comb begin
    pins_in = '{sclk: serial_clock, sdata: serial_data, strobe: serial_strobe,
                mode_sel: mode_select, tx_data: tx_data, standby_n: standby_n};
    meta_d = pins_in;
    sync_d = meta_q;
    sclk_prev_d = sync_q.sclk;
    strobe_prev_d = sync_q.strobe;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      sclk_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      sclk_prev_q <= sclk_prev_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  // ==========================================================
  // Serial shift register and latches, AXI writes
  logic [`ACC_W-1:0] shift_q, shift_d;
  dds_fsk_pkg::settings_t set_q, set_d;
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_be_q, w_be_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic do_write;
  logic [31:0] merged;

  always_comb begin
    shift_d = shift_q;
    set_d = set_q;
    // Data is only sampled on the clock edge, strobe loads at any clock level
    if (sync_q.sclk && !sclk_prev_q) begin
      shift_d = {shift_q[`ACC_W-2:0], sync_q.sdata};
    end
    if (sync_q.strobe && !strobe_prev_q) begin
      unique case (shift_q[`ADDR_HI:`ADDR_LO])
        `LATCH_MODE0: set_d.mode0_frequency_setting = shift_q[`FREQ_W-1:0];
        `LATCH_MODE1: set_d.mode1_frequency_setting = shift_q[`FREQ_W-1:0];
        `LATCH_CONTROL: set_d.control_word = shift_q;
        default: ;
      endcase
    end

    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_be_d = w_be_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    merged = 32'h0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_be_d = s_axi_wstrb;
    end
    do_write = aw_have_q && w_have_q && !bvalid_q;
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (aw_addr_q)
        `OFS_MODE0_FREQ: begin
          merged = strobe_merge({10'h000, set_q.mode0_frequency_setting}, w_data_q, w_be_q);
          set_d.mode0_frequency_setting = merged[`FREQ_W-1:0];
        end
        `OFS_MODE1_FREQ: begin
          merged = strobe_merge({10'h000, set_q.mode1_frequency_setting}, w_data_q, w_be_q);
          set_d.mode1_frequency_setting = merged[`FREQ_W-1:0];
        end
        `OFS_CONTROL: begin
          merged = strobe_merge({8'h00, set_q.control_word}, w_data_q, w_be_q);
          set_d.control_word = merged[`ACC_W-1:0];
        end
        default: ;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
  end

  // Settings reset only with aresetn, never by standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_q <= '0;
      set_q <= '{`RST_FREQ, `RST_FREQ, `RST_CONTROL};
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_be_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      set_q <= set_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_be_q <= w_be_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  // ==========================================================
  // Step, accumulator and sine table
  logic [`ACC_W-1:0] step_q, step_d;
  logic [`ACC_W-1:0] acc_q, acc_d;
  logic [`DAC_W-1:0] dac_q, dac_d;
  logic [`FREQ_W-1:0] freq_sel;
  logic [3:0] q_idx;
  logic [9:0] amp;

  always_comb begin
    freq_sel = sync_q.mode_sel ? set_q.mode1_frequency_setting : set_q.mode0_frequency_setting;
    step_d = {2'b00, freq_sel};
    if (!set_q.control_word[`MOD_SEL_BIT] && sync_q.tx_data) begin
      step_d = {2'b00, freq_sel} + {14'h0000, set_q.control_word[`DEV_W-1:0], 2'b00};
    end
    // Only the step changes; phase continues
    acc_d = sync_q.standby_n ? acc_q + step_q : acc_q;
    q_idx = acc_q[`ACC_W-2] ? ~acc_q[`ACC_W-3:`ACC_W-6] : acc_q[`ACC_W-3:`ACC_W-6];
    amp = quarter_amp(q_idx);
    dac_d = acc_q[`ACC_W-1] ? (11'h400 - {1'b0, amp}) : (11'h400 + {1'b0, amp});
  end

  // Reference clock is aclk throughout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_q <= '0;
      acc_q <= `RST_ACC;
      dac_q <= 11'h400;
    end else begin
      step_q <= step_d;
      acc_q <= acc_d;
      dac_q <= dac_d;
    end
  end

  // ==========================================================
  // AXI read
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_axi_araddr)
        `OFS_MODE0_FREQ: rdata_d = {10'h000, set_q.mode0_frequency_setting};
        `OFS_MODE1_FREQ: rdata_d = {10'h000, set_q.mode1_frequency_setting};
        `OFS_CONTROL: rdata_d = {8'h00, set_q.control_word};
        `OFS_PHASE: rdata_d = {8'h00, acc_q};
        `OFS_SAMPLE: rdata_d = {21'h000000, dac_q};
        `OFS_SHIFT: rdata_d = {8'h00, shift_q};
        default: rdata_d = 32'h0;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign dac_code = dac_q;
  assign phase = acc_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : dds_fsk_frequency_synth

`default_nettype wire

// *** dds_fsk_map.svh ***
`ifndef DDS_FSK_MAP_SVH
`define DDS_FSK_MAP_SVH

// ==========================================================
// Register byte offsets
`define OFS_MODE0_FREQ 8'h00
`define OFS_MODE1_FREQ 8'h04
`define OFS_CONTROL 8'h08
`define OFS_PHASE 8'h0c
`define OFS_SAMPLE 8'h10
`define OFS_SHIFT 8'h14

// ==========================================================
// Field positions and widths
`define ACC_W 24
`define FREQ_W 22
`define DEV_W 8
`define DAC_W 11
`define MOD_SEL_BIT 16
`define ADDR_HI 23
`define ADDR_LO 21

// ==========================================================
// Serial latch addresses
`define LATCH_MODE0 3'h0
`define LATCH_MODE1 3'h1
`define LATCH_CONTROL 3'h2

// ==========================================================
// Reset values
`define RST_FREQ 22'h000000
`define RST_CONTROL 24'h010000
`define RST_ACC 24'h000000

// ==========================================================
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** dds_fsk_pkg.sv ***
`default_nettype none
package dds_fsk_pkg;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic strobe;
    logic mode_sel;
    logic tx_data;
    logic standby_n;
  } pin_set_t;

  typedef struct packed {
    logic [21:0] mode0_frequency_setting;
    logic [21:0] mode1_frequency_setting;
    logic [23:0] control_word;
  } settings_t;

endpackage : dds_fsk_pkg
`default_nettype wire

// *** dds_fsk_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module dds_fsk_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic standby_n,
  input wire logic mode_select,
  input wire logic tx_data,
  input wire logic serial_strobe,
  input wire logic [23:0] phase,
  input wire logic [10:0] dac_code,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Accumulator
  sequence s_quiet;
    standby_n && $stable(mode_select) && $stable(tx_data) && !s_axi_awvalid && !serial_strobe;
  endsequence
  property p_slope;
    s_quiet [*8] |-> (phase - $past(phase)) == ($past(phase) - $past(phase, 2));
  endproperty
  a_slope: assert property (p_slope) else $error("step not constant");
  property p_freeze;
    !standby_n [*5] |-> $stable(phase) && $stable(dac_code);
  endproperty
  a_freeze: assert property (p_freeze) else $error("phase moved in standby");
  property p_sign;
    $past(aresetn) |-> (dac_code > 11'h400) == !$past(phase[23]);
  endproperty
  a_sign: assert property (p_sign) else $error("sample sign does not follow phase");
  // ==========================================
  // Register bus
  sequence s_wboth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_bans;
    s_wboth |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("no write response");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_wbusy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("write taken while busy");
  property p_rbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("no read answer");
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
endmodule : dds_fsk_monitor
bind dds_fsk_frequency_synth dds_fsk_monitor i_mon (.*);
`default_nettype wire

// *** dds_fsk_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module dds_fsk_host (
  output var logic serial_clock,
  output var logic serial_data,
  output var logic serial_strobe
);
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    serial_strobe = 1'b0;
  end
  // Sends n bits, first bit is the highest, then strobes
  // Pin edges land 5 ns after an aclk edge, never on one
  task automatic send(input logic [31:0] w, input int n);
    #5;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = w[i];
      #100 serial_clock = 1'b1;
      #25 serial_data = ~w[i];
      #75 serial_clock = 1'b0;
    end
    serial_data = 1'b0;
    #100 serial_strobe = 1'b1;
    #200 serial_strobe = 1'b0;
    #95;
  endtask : send
endmodule : dds_fsk_host
`default_nettype wire

// *** tb_dds_fsk_frequency_synth.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_dds_fsk_frequency_synth;
  logic aclk, aresetn, mode_select, tx_data, standby_n;
  logic serial_clock, serial_data, serial_strobe;
  logic [10:0] dac_code;
  logic [23:0] phase, p0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int bad_count, check_count, m0, m1, ctl;
  dds_fsk_frequency_synth i_dut (.*);
  dds_fsk_host i_host (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : compare
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    // Late bready lets the response be seen held
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd32(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    // Late rready lets the read data be seen held
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd32
  // Step seen over one cycle once pins have settled
  task automatic step_chk(input int exp);
    repeat (10) @(posedge aclk);
    p0 = phase;
    @(posedge aclk);
    compare({8'h0, 24'(phase - p0)}, 32'(exp) & 32'hffffff);
  endtask : step_chk
  initial begin
    {aresetn, mode_select, tx_data, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    standby_n = 1'b1;
    s_axi_wstrb = 4'hf;
    void'($urandom(94));
    m0 = 0;
    m1 = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    compare({8'h0, phase}, 32'h0);
    for (int i = 0; i < 12; i += 4) begin
      rd32(8'(i));
      compare(rd, (i == 8) ? 32'h10000 : 32'h0);
    end
    rd32(8'h40);
    compare(32'(rs), 32'h2);
    wr(8'h0c, 32'h0);
    compare(32'(rs), 32'h0);
    wr(8'h40, 32'h0);
    compare(32'(rs), 32'h2);
    s_axi_wstrb <= 4'h1;
    wr(8'h00, 32'hffffffff);
    s_axi_wstrb <= 4'hf;
    wr(8'h04, 32'hffffffff);
    rd32(8'h00);
    compare(rd, 32'hff);
    rd32(8'h04);
    compare(rd, 32'h3fffff);
    $display("test reset done");
    // ==========================================
    // Serial programming, extra leading bits dropped
    m0 = $urandom & 32'h1fffff;
    m1 = $urandom | 32'h200000;
    m1 = m1 & 32'h3fffff;
    i_host.send({8'h3, 24'(m0)}, 26);
    i_host.send(32'(m1), 24);
    @(posedge aclk);
    rd32(8'h00);
    compare(rd, 32'(m0));
    rd32(8'h04);
    compare(rd, 32'(m1));
    rd32(8'h14);
    compare(rd, 32'(m1));
    $display("test serial done");
    // ==========================================
    // Every mode, data level and modulation choice
    for (int k = 0; k < 8; k++) begin
      ctl = (k[2] ? 32'h10000 : 32'h0) | ($urandom & 32'hff);
      wr(8'h08, 32'(ctl));
      mode_select <= k[0];
      tx_data <= k[1];
      step_chk((k[0] ? m1 : m0) + ((!k[2] && k[1]) ? (ctl & 255) * 4 : 0));
    end
    $display("test step done");
    // ==========================================
    // Standby: phase frozen, settings kept
    standby_n <= 1'b0;
    repeat (5) @(posedge aclk);
    p0 = phase;
    m0 = $urandom & 32'h1fffff;
    i_host.send(32'(m0), 24);
    @(posedge aclk);
    compare({8'h0, phase}, {8'h0, p0});
    standby_n <= 1'b1;
    rd32(8'h00);
    compare(rd, 32'(m0));
    rd32(8'h04);
    compare(rd, 32'(m1));
    step_chk(m1);
    $display("test standby done");
    close_out();
  end
  initial begin
    #500000;
    bad_count++;
    close_out();
  end
endmodule : tb_dds_fsk_frequency_synth
`default_nettype wire
